// ---- rtl/rcie_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types of the instruction execution core.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Opcode, condition and source encodings are local to this block.
//////////////////////////////////////////////////////////////////////////////
package rcie_pkg;

    localparam int DATA_W      = 8;
    localparam int ADDR_W      = 16;
    localparam int NUM_REGS    = 16;
    localparam int REG_IDX_W   = 4;
    localparam int STACK_DEPTH = 8;
    localparam int DM_ADDR_W   = 8;

    // Internal register indices.
    localparam logic [REG_IDX_W-1:0] REG_IP_HI = 4'hC;
    localparam logic [REG_IDX_W-1:0] REG_IP_LO = 4'hD;
    localparam logic [REG_IDX_W-1:0] REG_STAT  = 4'hE;
    localparam logic [REG_IDX_W-1:0] REG_ACC   = 4'hF;

    localparam int STAT_GIE_BIT = 5;

    localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] PC_STEP  = 16'h0001;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;
    localparam logic [DATA_W-1:0] BYTE_ONES = 8'hFF;
    localparam logic [DATA_W-1:0] BYTE_SIGN = 8'h80;
    localparam logic [DATA_W-1:0] BYTE_SMAX = 8'h7F;

    typedef enum logic [5:0] {
        OP_NOP, OP_JUMP, OP_JUMP_IP, OP_JCC, OP_JCC_IP,
        OP_CALL, OP_CALL_IP, OP_CALLS, OP_CALLS_IP,
        OP_RET, OP_RETS, OP_RETI, OP_PUSH, OP_POP,
        OP_MOVE, OP_STORE_REG, OP_STORE_IMM, OP_CMV_CLR, OP_CMV_SET,
        OP_SHIFT_LEFT, OP_ROTATE_LEFT_CARRY, OP_SHIFT_RIGHT,
        OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH,
        OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT, OP_TWOS_COMPLEMENT_CARRY,
        OP_INC, OP_INC_CARRY, OP_DEC
    } rcie_op_e;

    typedef enum logic [2:0] {
        COND_C_SET, COND_C_CLR, COND_Z_SET, COND_Z_CLR,
        COND_V_SET, COND_V_CLR
    } rcie_cond_e;

    typedef enum logic [1:0] {
        SRC_IMM, SRC_REG, SRC_MEM
    } rcie_src_e;

    typedef struct packed {
        logic [STACK_DEPTH-1:0][ADDR_W-1:0] entry;
    } rcie_stack_s;

    typedef struct packed {
        logic [ADDR_W-1:0]                pc;
        logic [NUM_REGS-1:0][DATA_W-1:0]  regs;
        logic                             c;
        logic                             v;
        logic                             z;
        logic                             dm_we;
        logic [DM_ADDR_W-1:0]             dm_waddr;
        logic [DATA_W-1:0]                dm_wdata;
    } rcie_core_s;

endpackage : rcie_pkg

// ---- rtl/rcie_alu.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shift, complement, increment and decrement datapath.
// Assumes: Purely combinational; the caller decides which flags to keep.
// Notes:   Other opcodes pass the operand and the carry through.
//////////////////////////////////////////////////////////////////////////////
module rcie_alu
    import rcie_pkg::*;
(
    input  rcie_op_e          op,
    input  wire logic [7:0]   operand,
    input  wire logic         carry_in,
    output logic [7:0]        result,
    output logic              carry_out,
    output logic              ovf_out
);

    always_comb begin
        result    = operand;
        carry_out = carry_in;
        ovf_out   = 1'b0;
        unique case (op)
            OP_SHIFT_LEFT: begin
                result    = {operand[6:0], 1'b0};          // see RL13
                carry_out = operand[7];
                ovf_out   = operand[7] ^ operand[6];
            end
            OP_ROTATE_LEFT_CARRY: begin
                result    = {operand[6:0], carry_in};      // see RL14
                carry_out = operand[7];
                ovf_out   = operand[7] ^ operand[6];
            end
            OP_SHIFT_RIGHT: begin
                result    = {1'b0, operand[7:1]};          // see RL15
                carry_out = operand[0];
                ovf_out   = operand[7];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                result    = {carry_in, operand[7:1]};      // see RL15
                carry_out = operand[0];
                ovf_out   = carry_in ^ operand[7];
            end
            OP_SHIFT_RIGHT_ARITH: begin
                result    = {operand[7], operand[7:1]};    // see RL16
                carry_out = operand[0];
            end
            OP_ONES_COMPLEMENT: result = ~operand; // see RL17
            OP_TWOS_COMPLEMENT: begin
                result    = ~operand + BYTE_ONE;           // see RL17
                carry_out = (result == BYTE_ZERO);
                ovf_out   = (operand == BYTE_SIGN);
            end
            OP_TWOS_COMPLEMENT_CARRY: begin
                result    = ~operand + {7'h00, carry_in};  // see RL18
                carry_out = (result == BYTE_ZERO) && carry_in;
                ovf_out   = carry_in && (operand == BYTE_SIGN);
            end
            OP_INC: begin
                result    = operand + BYTE_ONE;            // see RL19
                carry_out = (result == BYTE_ZERO);
                ovf_out   = (operand == BYTE_SMAX);
            end
            OP_INC_CARRY: begin
                result    = operand + {7'h00, carry_in};   // see RL19
                carry_out = (result == BYTE_ZERO) && carry_in;
                ovf_out   = carry_in && (operand == BYTE_SMAX);
            end
            OP_DEC: begin
                result    = operand - BYTE_ONE;            // see RL20
                carry_out = (result != BYTE_ONES);
                ovf_out   = (operand == BYTE_SIGN);
            end
            default: ;
        endcase
    end

endmodule : rcie_alu

// ---- rtl/rcie_stack.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Hardware return stack of fixed depth.
// Assumes: Push and pop are never asserted together.
// Notes:   Overflow drops the deepest entry; underflow fills with zero.
//////////////////////////////////////////////////////////////////////////////
module rcie_stack
    import rcie_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               push,
    input  wire logic               pop,
    input  wire logic [ADDR_W-1:0]  push_data,
    output logic [ADDR_W-1:0]       top
);

    rcie_stack_s st_r;
    rcie_stack_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            for (int i = STACK_DEPTH - 1; i > 0; i--) begin
                st_nxt.entry[i] = st_r.entry[i-1];         // see RL3
            end
            st_nxt.entry[0] = push_data;
        end else if (pop) begin
            for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                st_nxt.entry[i] = st_r.entry[i+1];         // see RL6
            end
            st_nxt.entry[STACK_DEPTH-1] = PC_RESET;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign top = st_r.entry[0];

endmodule : rcie_stack

// ---- rtl/rcie_core.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Single-cycle execution of control-flow, move, shift,
//          complement, increment and decrement instructions.
// Assumes: The instruction at PC and its data memory operand are presented
//          combinationally in the same cycle.
// Notes:   Stores to data memory leave through registered outputs.
//
// Notes on behaviour
// RL1 - Jumps load target when condition holds
// RL2 - Register conditional jump targets program index
// RL3 - Call pushes stack, saves PC plus one
// RL4 - Register call targets program index
// RL5 - Short call uses program index; return reloads
// RL6 - Return pops top entry into PC
// RL7 - Interrupt return also sets global enable
// RL8 - Push stores program index on stack
// RL9 - Pop loads program index from stack
// RL10 - Moves write destination and accumulator
// RL11 - Move-if-carry-clear writes destination when C=0
// RL12 - Move-if-carry-set writes destination when C=1
// RL13 - Left shift fills zero, bit seven to carry
// RL14 - Left rotate fills bit zero from carry
// RL15 - Right shift/rotate, bit zero to carry
// RL16 - Arithmetic right shift keeps sign bit
// RL17 - Complements invert; two's adds one, carry set on zero result
// RL18 - Two's complement with carry adds carry
// RL19 - Increment sets carry on wrap to zero
// RL20 - Decrement clears carry on all ones
// RL21 - Every instruction completes in one cycle
// RL22 - Zero flag tracks accumulator equal to zero
// RL23 - Flags touched only by the proper classes
//////////////////////////////////////////////////////////////////////////////
module rcie_core
    import rcie_pkg::*;
(
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST,
    input  rcie_op_e                   INSTR_OP,
    input  rcie_cond_e                 INSTR_COND,
    input  rcie_src_e                  INSTR_SRC_SEL,
    input  wire logic [REG_IDX_W-1:0]  INSTR_DST,
    input  wire logic [REG_IDX_W-1:0]  INSTR_SRC,
    input  wire logic [DATA_W-1:0]     INSTR_DATA,
    input  wire logic [ADDR_W-1:0]     INSTR_ADDR,
    input  wire logic [DATA_W-1:0]     DM_RDATA,
    output logic [ADDR_W-1:0]          PC,
    output logic [DATA_W-1:0]          ACC,
    output logic                       FLAG_C,
    output logic                       FLAG_V,
    output logic                       FLAG_Z,
    output logic                       GLOBAL_IRQ_ENABLE,
    output logic [ADDR_W-1:0]          PROGRAM_INDEX,
    output logic [ADDR_W-1:0]          STACK_TOP,
    output logic                       DM_WE,
    output logic [DM_ADDR_W-1:0]       DM_WADDR,
    output logic [DATA_W-1:0]          DM_WDATA
);

    //////////////////////////////////////////////////////////////////////////

    function automatic logic cond_holds(input rcie_cond_e cond,
                                        input logic       c,
                                        input logic       v,
                                        input logic       z);
        logic res;
        unique case (cond)
            COND_C_SET: res = c;
            COND_C_CLR: res = !c;
            COND_Z_SET: res = z;
            COND_Z_CLR: res = !z;
            COND_V_SET: res = v;
            COND_V_CLR: res = !v;
            default:    res = 1'b0;
        endcase
        return res;
    endfunction : cond_holds

    rcie_core_s           st_r;
    rcie_core_s           st_nxt;
    logic [ADDR_W-1:0]    program_index_reg;
    logic [ADDR_W-1:0]    pc_seq;
    logic [DATA_W-1:0]    operand;
    logic [DATA_W-1:0]    alu_result;
    logic                 alu_c;
    logic                 alu_v;
    logic                 stack_push;
    logic                 stack_pop;
    logic [ADDR_W-1:0]    stack_push_data;
    logic [ADDR_W-1:0]    return_stack_entry;

    assign program_index_reg = {st_r.regs[REG_IP_HI], st_r.regs[REG_IP_LO]};
    assign pc_seq            = st_r.pc + PC_STEP;

    always_comb begin
        unique case (INSTR_SRC_SEL)
            SRC_IMM: operand = INSTR_DATA;
            SRC_REG: operand = st_r.regs[INSTR_SRC];
            SRC_MEM: operand = DM_RDATA;
            default: operand = BYTE_ZERO;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////

    // Stack traffic is decoded here so that it lands in the same cycle.
    assign stack_push = (INSTR_OP == OP_CALL) || (INSTR_OP == OP_CALL_IP)
                        || (INSTR_OP == OP_PUSH);           // see RL3
    assign stack_pop  = (INSTR_OP == OP_RET) || (INSTR_OP == OP_RETI)
                        || (INSTR_OP == OP_POP);            // see RL6
    assign stack_push_data = (INSTR_OP == OP_PUSH) ? program_index_reg
                                                   : pc_seq; // see RL8

    rcie_stack u_stack (
        .clk       (SYS_CLK),
        .rst       (RST),
        .push      (stack_push),
        .pop       (stack_pop),
        .push_data (stack_push_data),
        .top       (return_stack_entry)
    );

    rcie_alu u_alu (
        .op        (INSTR_OP),
        .operand   (operand),
        .carry_in  (st_r.c),
        .result    (alu_result),
        .carry_out (alu_c),
        .ovf_out   (alu_v)
    );

    //////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_nxt       = st_r;
        st_nxt.pc    = pc_seq;                              // see RL21
        st_nxt.dm_we = 1'b0;
        unique case (INSTR_OP)
            OP_NOP, OP_PUSH: ;                  // see RL8
            OP_JUMP:    st_nxt.pc = INSTR_ADDR; // see RL1
            OP_JUMP_IP: st_nxt.pc = program_index_reg;
            OP_JCC, OP_JCC_IP: begin
                if (cond_holds(INSTR_COND, st_r.c, st_r.v, st_r.z)) begin
                    st_nxt.pc = (INSTR_OP == OP_JCC) ? INSTR_ADDR // see RL1
                              : program_index_reg; // see RL2
                end
            end
            OP_CALL:    st_nxt.pc = INSTR_ADDR; // see RL3
            OP_CALL_IP: st_nxt.pc = program_index_reg; // see RL4
            OP_CALLS, OP_CALLS_IP: begin
                // The register form jumps to the index before the save.
                st_nxt.regs[REG_IP_HI] = pc_seq[15:8]; // see RL5
                st_nxt.regs[REG_IP_LO] = pc_seq[7:0];
                st_nxt.pc = (INSTR_OP == OP_CALLS) ? INSTR_ADDR
                          : program_index_reg;
            end
            OP_RET:  st_nxt.pc = return_stack_entry; // see RL6
            OP_RETS: st_nxt.pc = program_index_reg; // see RL5
            OP_RETI: begin
                st_nxt.pc = return_stack_entry;             // see RL7
                st_nxt.regs[REG_STAT][STAT_GIE_BIT] = 1'b1;
            end
            OP_POP: begin
                st_nxt.regs[REG_IP_HI] = return_stack_entry[15:8]; // see RL9
                st_nxt.regs[REG_IP_LO] = return_stack_entry[7:0];
            end
            OP_MOVE: begin
                st_nxt.regs[INSTR_DST] = operand;           // see RL10
                st_nxt.regs[REG_ACC]   = operand;
                st_nxt.z = (operand == BYTE_ZERO);          // see RL22
            end
            OP_STORE_REG, OP_STORE_IMM: begin
                st_nxt.dm_we    = 1'b1; // see RL23
                st_nxt.dm_waddr = INSTR_ADDR[DM_ADDR_W-1:0];
                st_nxt.dm_wdata = (INSTR_OP == OP_STORE_IMM) ? INSTR_DATA
                                : st_r.regs[INSTR_SRC];
            end
            OP_CMV_CLR, OP_CMV_SET: begin
                if (st_r.c == (INSTR_OP == OP_CMV_SET)) begin
                    st_nxt.regs[INSTR_DST] = operand; // see RL11, RL12
                end
                st_nxt.regs[REG_ACC] = operand;
                st_nxt.z = (operand == BYTE_ZERO); // see RL22
            end
            OP_ONES_COMPLEMENT: begin
                st_nxt.regs[INSTR_DST] = alu_result;        // see RL17
                st_nxt.regs[REG_ACC]   = alu_result;
                st_nxt.z = (alu_result == BYTE_ZERO);       // see RL23
            end
            OP_SHIFT_LEFT, OP_ROTATE_LEFT_CARRY, OP_SHIFT_RIGHT,
            OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH,
            OP_TWOS_COMPLEMENT, OP_TWOS_COMPLEMENT_CARRY,
            OP_INC, OP_INC_CARRY, OP_DEC: begin
                st_nxt.regs[INSTR_DST] = alu_result;        // see RL13
                st_nxt.regs[REG_ACC]   = alu_result;
                st_nxt.c = alu_c;                           // see RL23
                st_nxt.v = alu_v;
                st_nxt.z = (alu_result == BYTE_ZERO);       // see RL22
            end
            default: ;
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            st_r   <= '0;
            st_r.z <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////

    assign PC                = st_r.pc;
    assign ACC               = st_r.regs[REG_ACC];
    assign FLAG_C            = st_r.c;
    assign FLAG_V            = st_r.v;
    assign FLAG_Z            = st_r.z;
    assign GLOBAL_IRQ_ENABLE = st_r.regs[REG_STAT][STAT_GIE_BIT];
    assign PROGRAM_INDEX     = program_index_reg;
    assign STACK_TOP         = return_stack_entry;
    assign DM_WE             = st_r.dm_we;
    assign DM_WADDR          = st_r.dm_waddr;
    assign DM_WDATA          = st_r.dm_wdata;

endmodule : rcie_core

// ---- sim/rcie_dmem.sv ----
// Purpose: Data memory seen by the execution core.
// Assumes: Read is combinational; a store lands at the edge that sees it.
// Notes:   Cells start from the pattern address XOR 8'h5A so a stale read shows.
module rcie_dmem
    import rcie_pkg::*;
(
    input  wire logic [0:0]           sys_clk,
    input  wire logic                 we,
    input  wire logic [DM_ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0]    wdata,
    input  wire logic [DM_ADDR_W-1:0] raddr,
    output logic [DATA_W-1:0]         rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DATA_W-1:0] mem [256];

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end

    always @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule : rcie_dmem

// ---- sim/rcie_core_chk.sv ----
// Purpose: Concurrent checks on the ports of the execution core.
// Assumes: One clock domain, reset RST active high.
// Notes:   Attached to every instance of the core by bind.
module rcie_core_chk
    import rcie_pkg::*;
(
    input wire logic              SYS_CLK,
    input wire logic              RST,
    input rcie_op_e               INSTR_OP,
    input rcie_src_e              INSTR_SRC_SEL,
    input wire logic [DATA_W-1:0] INSTR_DATA,
    input wire logic [ADDR_W-1:0] INSTR_ADDR,
    input wire logic [ADDR_W-1:0] PC,
    input wire logic [DATA_W-1:0] ACC,
    input wire logic              FLAG_C,
    input wire logic              FLAG_V,
    input wire logic              FLAG_Z,
    input wire logic              GLOBAL_IRQ_ENABLE,
    input wire logic [ADDR_W-1:0] PROGRAM_INDEX,
    input wire logic [ADDR_W-1:0] STACK_TOP,
    input wire logic              DM_WE,
    input wire logic [DATA_W-1:0] DM_WDATA
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    a_jump_target: assert property (
        INSTR_OP == OP_JUMP |=> PC == $past(INSTR_ADDR))
        else $error("bad jump");
    a_call_push: assert property (
        INSTR_OP == OP_CALL |=> PC == $past(INSTR_ADDR)
            && STACK_TOP == $past(PC) + 16'h0001)
        else $error("bad call");
    a_ret_pop: assert property (
        INSTR_OP == OP_RET |=> PC == $past(STACK_TOP))
        else $error("bad return");
    a_reti_enable: assert property (
        INSTR_OP == OP_RETI |=> GLOBAL_IRQ_ENABLE
            && PC == $past(STACK_TOP))
        else $error("bad interrupt return");
    a_push_index: assert property (
        INSTR_OP == OP_PUSH |=> STACK_TOP == $past(PROGRAM_INDEX)
            && PC == $past(PC) + 16'h0001)
        else $error("bad push");
    a_pop_index: assert property (
        INSTR_OP == OP_POP |=> PROGRAM_INDEX == $past(STACK_TOP))
        else $error("bad pop");
    a_zero_track: assert property (
        FLAG_Z == (ACC == 8'h00))
        else $error("bad zero flag");
    a_flow_quiet: assert property (
        INSTR_OP inside {[OP_JUMP:OP_POP]} |=> $stable(ACC)
            && $stable(FLAG_C) && $stable(FLAG_V))
        else $error("flow touched data");
    a_store_pulse: assert property (
        INSTR_OP == OP_STORE_IMM |=> DM_WE
            && DM_WDATA == $past(INSTR_DATA))
        else $error("bad store");
    a_shift_left: assert property (
        INSTR_OP == OP_SHIFT_LEFT && INSTR_SRC_SEL == SRC_IMM
            |=> {FLAG_C, ACC} == {1'b0, $past(INSTR_DATA)} << 1)
        else $error("bad left shift");

endmodule : rcie_core_chk

bind rcie_core rcie_core_chk i_rcie_core_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .INSTR_OP(INSTR_OP),
    .INSTR_SRC_SEL(INSTR_SRC_SEL), .INSTR_DATA(INSTR_DATA),
    .INSTR_ADDR(INSTR_ADDR), .PC(PC), .ACC(ACC), .FLAG_C(FLAG_C),
    .FLAG_V(FLAG_V), .FLAG_Z(FLAG_Z),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .PROGRAM_INDEX(PROGRAM_INDEX),
    .STACK_TOP(STACK_TOP), .DM_WE(DM_WE), .DM_WDATA(DM_WDATA)
);

// ---- sim/rcie_core_tb.sv ----
// Purpose: Self-checking bench for the execution core.
// Assumes: Inputs change at the falling edge, outputs read there too.
// Notes:   Overflow flag values follow the core's own choices.
module rcie_core_tb
    import rcie_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk, rst, fc, fv, fz, global_irq_enable, dm_we;
    rcie_op_e    op;
    rcie_cond_e  cond;
    rcie_src_e   sel;
    logic [3:0]  dst, src;
    logic [7:0]  data, dm_rdata, acc, dm_waddr, dm_wdata;
    logic [15:0] addr, pc, pidx, top;
    int          err_total, checks_done, cycles;

    rcie_core i_rcie_core (.SYS_CLK(sys_clk), .RST(rst), .INSTR_OP(op),
        .INSTR_COND(cond), .INSTR_SRC_SEL(sel), .INSTR_DST(dst),
        .INSTR_SRC(src), .INSTR_DATA(data), .INSTR_ADDR(addr),
        .DM_RDATA(dm_rdata), .PC(pc), .ACC(acc), .FLAG_C(fc), .FLAG_V(fv),
        .FLAG_Z(fz), .GLOBAL_IRQ_ENABLE(global_irq_enable), .PROGRAM_INDEX(pidx),
        .STACK_TOP(top), .DM_WE(dm_we), .DM_WADDR(dm_waddr),
        .DM_WDATA(dm_wdata));
    rcie_dmem i_rcie_dmem (.sys_clk(sys_clk), .we(dm_we), .waddr(dm_waddr),
        .wdata(dm_wdata), .raddr(addr[7:0]), .rdata(dm_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks=%0d errors=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            final_report();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One instruction: presented now, executed at the next rising edge.
    task automatic go(input rcie_op_e o, input logic [7:0] d = 8'h00,
                      input logic [15:0] a = 16'h0000);
        op = o;
        data = d;
        addr = a;
        @(negedge sys_clk);
    endtask : go

    task automatic setc(input logic b);
        sel = SRC_IMM;
        dst = 4'h0;
        go(OP_SHIFT_LEFT, {b, 7'h00});
    endtask : setc

    function automatic logic [8:0] model(rcie_op_e o, logic [7:0] d,
                                         logic ci);
        logic [7:0] t2, t2c, i1, ic, d1;
        t2 = ~d + 8'h01;
        t2c = ~d + {7'h00, ci};
        i1 = d + 8'h01;
        ic = d + {7'h00, ci};
        d1 = d - 8'h01;
        case (o)
            OP_SHIFT_LEFT:            return {d, 1'b0};
            OP_ROTATE_LEFT_CARRY:     return {d, ci};
            OP_SHIFT_RIGHT:           return {d[0], 1'b0, d[7:1]};
            OP_ROTATE_RIGHT_CARRY:    return {d[0], ci, d[7:1]};
            OP_SHIFT_RIGHT_ARITH:     return {d[0], d[7], d[7:1]};
            OP_ONES_COMPLEMENT:       return {ci, ~d};
            OP_TWOS_COMPLEMENT:       return {t2 == 8'h00, t2};
            OP_TWOS_COMPLEMENT_CARRY: return {t2c == 8'h00 && ci, t2c};
            OP_INC:                   return {i1 == 8'h00, i1};
            OP_INC_CARRY:             return {ic == 8'h00 && ci, ic};
            default:                  return {d1 != 8'hFF, d1};
        endcase
    endfunction : model

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rst = 1'b1;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        chk(pc, 16'h0000);
        chk(top, 16'h0000);
        chk(16'({fz, fc, fv, global_irq_enable, dm_we, acc}), 16'h1000);
    endtask : t_reset

    task automatic t_mem();
        go(OP_STORE_IMM, 8'hA7, 16'h0035);
        chk(16'({dm_we, dm_waddr, dm_wdata}), 16'h35A7);
        chk(16'(dm_we), 16'h0001);
        go(OP_NOP);
        chk(16'(dm_we), 16'h0000);
        sel = SRC_MEM;
        dst = 4'h1;
        go(OP_MOVE, 8'h00, 16'h0035);
        chk(16'({fz, acc}), 16'h00A7);
        sel = SRC_REG;
        src = 4'h1;
        dst = 4'h3;
        go(OP_MOVE);
        chk(16'(acc), 16'h00A7);
        sel = SRC_IMM;
        go(OP_MOVE, 8'h00);
        chk(16'({fz, acc}), 16'h0100);
    endtask : t_mem

    task automatic t_alu();
        rcie_op_e ops [11] = '{OP_SHIFT_LEFT, OP_ROTATE_LEFT_CARRY,
            OP_SHIFT_RIGHT, OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH,
            OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT,
            OP_TWOS_COMPLEMENT_CARRY, OP_INC, OP_INC_CARRY, OP_DEC};
        logic [7:0] din [11] = '{8'hC1, 8'h41, 8'h81, 8'h02, 8'h81, 8'hFF,
            8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};
        logic [8:0] e;
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 11; i++) begin
                setc(c[0]);
                e = model(ops[i], din[i], c[0]);
                dst = 4'h2;
                go(ops[i], din[i]);
                chk(16'({fc, acc}), 16'(e));
                chk(16'(fz), 16'(e[7:0] == 8'h00));
                sel = SRC_REG;
                src = 4'h2;
                go(OP_MOVE);
                chk(16'(acc), 16'(e[7:0]));
            end
        end
    endtask : t_alu

    task automatic cm(input rcie_op_e o, input logic [7:0] d,
                      input logic [7:0] e);
        sel = SRC_IMM;
        dst = 4'h1;
        go(o, d);
        chk(16'(acc), 16'(d));
        sel = SRC_REG;
        src = 4'h1;
        dst = 4'h3;
        go(OP_MOVE);
        chk(16'(acc), 16'(e));
    endtask : cm

    task automatic t_cmov();
        setc(1'b0);
        cm(OP_CMV_SET, 8'h44, 8'hA7);
        cm(OP_CMV_CLR, 8'h55, 8'h55);
        setc(1'b1);
        cm(OP_CMV_CLR, 8'h66, 8'h55);
        cm(OP_CMV_SET, 8'h77, 8'h77);
    endtask : t_cmov

    task automatic t_flow();
        logic [15:0] p, q, t;
        logic [5:0]  taken = 6'b011010;
        sel = SRC_IMM;
        dst = 4'h2;
        go(OP_INC, 8'h7F);
        for (int i = 0; i < 6; i++) begin
            cond = rcie_cond_e'(i);
            p = pc;
            t = 16'h4000 + 16'(i);
            go(OP_JCC, 8'h00, t);
            chk(pc, taken[i] ? t : p + 16'h0001);
        end
        dst = 4'hC;
        go(OP_MOVE, 8'h56);
        dst = 4'hD;
        go(OP_MOVE, 8'h78);
        cond = COND_C_CLR;
        go(OP_JCC_IP);
        chk(pc, 16'h5678);
        cond = COND_C_SET;
        go(OP_JCC_IP);
        chk(pc, 16'h5679);
        go(OP_JUMP, 8'h00, 16'h1234);
        go(OP_JUMP_IP);
        chk(pc, 16'h5678);
        go(OP_CALL, 8'h00, 16'h2000);
        chk(top, 16'h5679);
        go(OP_CALL_IP);
        chk({pc ^ top}, 16'h5678 ^ 16'h2001);
        go(OP_RET);
        chk({pc ^ top}, 16'h2001 ^ 16'h5679);
        go(OP_RETI);
        chk({pc ^ top}, 16'h5679);
        chk(16'(global_irq_enable), 16'h0001);
        go(OP_PUSH);
        chk(top, 16'h5678);
        dst = 4'hC;
        go(OP_MOVE, 8'h00);
        go(OP_POP);
        chk({pidx ^ top}, 16'h5678);
        p = pc;
        go(OP_CALLS, 8'h00, 16'h3000);
        chk({pc ^ pidx}, 16'h3000 ^ (p + 16'h0001));
        go(OP_RETS);
        go(OP_NOP);
        go(OP_NOP);
        p = pc;
        q = pidx;
        go(OP_CALLS_IP);
        chk({pc ^ pidx}, q ^ (p + 16'h0001));
        chk(16'({fc, fv}), 16'h0001);
    endtask : t_flow

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {dst, src, data, addr} = '0;
        {op, cond, sel} = {OP_NOP, COND_C_SET, SRC_IMM};
        t_reset();
        t_mem();
        t_alu();
        t_cmov();
        t_reset();
        t_flow();
        final_report();
    end

endmodule : rcie_core_tb
